// ===== bench/fxp_ctrl_bench.sv
// fxp_ctrl_bench: directed bench for the fax pump control block
// assumes fxp_host for commands; bench drives pump status and pin
`timescale 1ns/1ns
`default_nettype none
module fxp_ctrl_bench;
  localparam int           U = fxp_pkg::FXP_SIL_UNIT_CYC;
  logic                    clk_sys = 1'b0;
  logic                    resetn = 1'b0;
  logic                    cmd_valid;
  fxp_pkg::fxp_cmd_msg_t   cmd_msg;
  fxp_pkg::fxp_pump_stat_t st = '0;
  logic                    sil_pin = 1'b0;
  fxp_pkg::fxp_evt_msg_t   evt_msg;
  logic                    evt_valid;
  fxp_pkg::fxp_frame_t     frm;
  logic                    mod_on;
  logic                    tx_dir;
  logic [15:0]             rate;
  logic                    en;
  logic                    brk;
  logic                    go;
  logic                    brk_seen = 1'b0;
  int                      cyc = 0;
  int                      n_fail = 0;
  int                      total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (brk) brk_seen <= 1'b1;
  end
  fxp_ctrl dut_u (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_msg(cmd_msg), .pump_stat(st), .line_silent_pin(sil_pin),
    .evt_msg(evt_msg), .evt_valid(evt_valid), .serial_frame_mode(frm),
    .pump_modulation_on(mod_on), .pump_tx_dir(tx_dir), .pump_rate(rate),
    .pump_enable(en), .pump_break(brk), .transfer_go(go));
  fxp_host host_u (.clk_sys(clk_sys), .evt_valid(evt_valid),
    .evt_msg(evt_msg), .cmd_valid(cmd_valid), .cmd_msg(cmd_msg));
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ps(input logic [5:0] v);
    @(negedge clk_sys);
    st = v;
  endtask
  // bounded wait for exactly one new event, then compare its code
  task automatic ev(input fxp_pkg::fxp_evt_t e, input int lim);
    int n0;
    int k;
    n0 = host_u.n_evt;
    k = 0;
    while (host_u.n_evt == n0 && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    chk({host_u.n_evt - n0 == 1, host_u.last_evt}, {1'b1, e});
  endtask
  task automatic proc(input fxp_pkg::fxp_cmd_t c, input fxp_pkg::fxp_evt_t le,
    input fxp_pkg::fxp_frame_t f, input logic tx, input logic ab);
    host_u.send(c, {12'h0A5, c}, 1'b1);
    chk({frm, mod_on, tx_dir, rate},
        {f, 1'b1, tx, 12'h0A5, c});
    ps(6'h20);
    ev(le, 8);
    if (c == fxp_pkg::FXP_CMD_HDLC_RX) begin
      ps(6'h21);
      ev(fxp_pkg::FXP_EVT_FLAGS, 8);
    end
    host_u.send(fxp_pkg::FXP_CMD_CONTINUE, 16'h0000, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk(go, 1'b1);
    ps(6'h30);
    ev(fxp_pkg::FXP_EVT_CONNECT, 8);
    chk(host_u.last_info, {12'h0A5, c});
    host_u.send(fxp_pkg::FXP_CMD_SHUTDOWN, 16'h0000, 1'b0);
    host_u.send(fxp_pkg::FXP_CMD_BIN_RX, 16'h1234, 1'b1);
    chk({en, frm, rate}, {1'b1, f, 12'h0A5, c});
    brk_seen = 1'b0;
    if (ab) host_u.send(fxp_pkg::FXP_CMD_ABORT, 16'h0000, 1'b0);
    else ps(6'h38);
    repeat (3) @(negedge clk_sys);
    chk(brk_seen, ab && tx);
    ps(st | 6'h04);
    ev(fxp_pkg::FXP_EVT_MOD_OFF, 8);
    chk({frm, go}, {fxp_pkg::FXP_FRM_OFF, 1'b0});
    ps(6'h00);
  endtask
  task automatic sil(input logic [15:0] p, input logic hp);
    int t0;
    host_u.send(fxp_pkg::FXP_CMD_SIL_WAIT, p, hp);
    t0 = cyc;
    ev(fxp_pkg::FXP_EVT_SIL_ELAPSE, 3 * U);
    chk(cyc - t0 >= 2 * U && cyc - t0 < 2 * U + 200, 1'b1);
  endtask
  initial begin
    #(40000 * 4);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    // buffer and timeslot set-up lie outside; pump set-up first
    host_u.send(fxp_pkg::FXP_CMD_ANSWER, 16'h0000, 1'b0);
    ev(fxp_pkg::FXP_EVT_INIT, 8);
    host_u.send(fxp_pkg::FXP_CMD_ABORT, 16'h0000, 1'b0);
    repeat (4) @(negedge clk_sys);
    chk({brk_seen, 19'(host_u.n_evt)}, 20'h00001);
    // answering side listens first
    proc(fxp_pkg::FXP_CMD_HDLC_RX, fxp_pkg::FXP_EVT_LINE_HRX,
      fxp_pkg::FXP_FRM_HDLC, 1'b0, 1'b1);
    proc(fxp_pkg::FXP_CMD_HDLC_TX, fxp_pkg::FXP_EVT_LINE_HTX,
      fxp_pkg::FXP_FRM_HDLC, 1'b1, 1'b0);
    proc(fxp_pkg::FXP_CMD_BIN_TX, fxp_pkg::FXP_EVT_LINE_BTX,
      fxp_pkg::FXP_FRM_BINARY, 1'b1, 1'b1);
    proc(fxp_pkg::FXP_CMD_BIN_RX, fxp_pkg::FXP_EVT_LINE_BRX,
      fxp_pkg::FXP_FRM_BINARY, 1'b0, 1'b1);
    host_u.send(fxp_pkg::FXP_CMD_HDLC_RX, 16'h0003, 1'b1);
    ps(6'h20);
    ev(fxp_pkg::FXP_EVT_LINE_HRX, 8);
    ps(6'h22);
    ev(fxp_pkg::FXP_EVT_WRONG_CAR, 8);
    ps(6'h00);
    sil_pin = 1'b1;
    sil(16'h0002, 1'b1);
    sil(16'hFFFF, 1'b0);
    host_u.send(fxp_pkg::FXP_CMD_SIL_WAIT, 16'h0001, 1'b1);
    repeat (100) @(negedge clk_sys);
    host_u.send(fxp_pkg::FXP_CMD_SIL_STOP, 16'h0000, 1'b0);
    repeat (2 * U) @(negedge clk_sys);
    chk(host_u.last_evt, fxp_pkg::FXP_EVT_SIL_ELAPSE);
    chk(19'(host_u.n_evt), 19'd18);
    sil_pin = 1'b0;
    host_u.send(fxp_pkg::FXP_CMD_SHUTDOWN, 16'h0000, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk(en, 1'b0);
    host_u.send(fxp_pkg::FXP_ORIGINATE_MODE_CMD, 16'h0000, 1'b0);
    ev(fxp_pkg::FXP_EVT_INIT, 8);
    // originating side sends first
    proc(fxp_pkg::FXP_CMD_HDLC_TX, fxp_pkg::FXP_EVT_LINE_HTX,
      fxp_pkg::FXP_FRM_HDLC, 1'b1, 1'b0);
    summarize();
  end
endmodule // fxp_ctrl_bench
bind fxp_ctrl fxp_props props_u (.clk_sys(clk_sys), .resetn(resetn),
  .cmd_valid(cmd_valid), .cmd_msg(cmd_msg), .pump_stat(pump_stat),
  .line_silent_pin(line_silent_pin), .evt_msg(evt_msg),
  .evt_valid(evt_valid), .serial_frame_mode(serial_frame_mode),
  .pump_modulation_on(pump_modulation_on), .pump_tx_dir(pump_tx_dir),
  .pump_rate(pump_rate), .pump_enable(pump_enable),
  .pump_break(pump_break), .transfer_go(transfer_go));
`default_nettype wire

// ===== bench/fxp_host.sv
// fxp_host: host model, sends commands and logs pump events
// assumes falling-edge launch; one strobe cycle per command
`timescale 1ns/1ns
`default_nettype none
module fxp_host (
  input  wire logic                  clk_sys,
  input  wire logic                  evt_valid,
  input  wire fxp_pkg::fxp_evt_msg_t evt_msg,
  output logic                       cmd_valid,
  output fxp_pkg::fxp_cmd_msg_t      cmd_msg
);
  fxp_pkg::fxp_evt_t last_evt = fxp_pkg::FXP_EVT_NONE;
  int                n_evt = 0;
  logic [15:0]       last_info = 16'h0000;
  initial begin
    cmd_valid = 1'b0;
    cmd_msg = '0;
  end
  always @(posedge clk_sys) begin
    if (evt_valid) begin
      last_evt = evt_msg.code;
      last_info = evt_msg.info;
      n_evt = n_evt + 1;
    end
  end
  // framing only ever set by command, never directly
  // continue is sent by the caller only after the line event
  task automatic send(input fxp_pkg::fxp_cmd_t c, input logic [15:0] p,
                      input logic hp);
    @(negedge clk_sys);
    cmd_msg = {c, hp, p};
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    // stale bits inverted so a late sample never looks valid
    cmd_msg = ~cmd_msg;
  endtask
endmodule // fxp_host
`default_nettype wire

// ===== bench/fxp_props.sv
// fxp_props: assertions on the fxp_ctrl ports
// assumes one clk_sys domain; bound from the bench top file
`timescale 1ns/1ns
`default_nettype none
module fxp_props (
  input wire logic                    clk_sys,
  input wire logic                    resetn,
  input wire logic                    cmd_valid,
  input wire fxp_pkg::fxp_cmd_msg_t   cmd_msg,
  input wire fxp_pkg::fxp_pump_stat_t pump_stat,
  input wire logic                    line_silent_pin,
  input wire fxp_pkg::fxp_evt_msg_t   evt_msg,
  input wire logic                    evt_valid,
  input wire fxp_pkg::fxp_frame_t     serial_frame_mode,
  input wire logic                    pump_modulation_on,
  input wire logic                    pump_tx_dir,
  input wire logic [15:0]             pump_rate,
  input wire logic                    pump_enable,
  input wire logic                    pump_break,
  input wire logic                    transfer_go
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  fxp_pkg::fxp_cmd_t cc;
  fxp_pkg::fxp_evt_t ec;
  logic              idle;
  logic              sil_reg;
  logic              start;
  assign cc = cmd_valid ? cmd_msg.code : fxp_pkg::FXP_CMD_NONE;
  assign ec = evt_valid ? evt_msg.code : fxp_pkg::FXP_EVT_NONE;
  assign start = cc inside
    {[fxp_pkg::FXP_CMD_HDLC_TX:fxp_pkg::FXP_CMD_BIN_RX]};
  // silence wait shows on no port, so track it here
  assign idle = pump_enable && serial_frame_mode == fxp_pkg::FXP_FRM_OFF
    && !pump_modulation_on && !sil_reg;
  always_ff @(posedge clk_sys) begin
    if (!resetn || cc == fxp_pkg::FXP_CMD_SIL_STOP
        || ec == fxp_pkg::FXP_EVT_SIL_ELAPSE)
      sil_reg <= 1'b0;
    else if (cc == fxp_pkg::FXP_CMD_SIL_WAIT && idle)
      sil_reg <= 1'b1;
  end
  property p_init;
    (cc == fxp_pkg::FXP_CMD_ANSWER || cc == fxp_pkg::FXP_ORIGINATE_MODE_CMD)
      && !pump_enable |=> ec == fxp_pkg::FXP_EVT_INIT;
  endproperty
  a_init: assert property (p_init) else $error("no init event");
  property p_start;
    start && idle |=> pump_modulation_on && pump_rate == $past(cmd_msg.param)
      && pump_tx_dir == $past(cmd_msg.code[0]) && serial_frame_mode ==
      ($past(cmd_msg.code) < fxp_pkg::FXP_CMD_BIN_TX ?
       fxp_pkg::FXP_FRM_HDLC : fxp_pkg::FXP_FRM_BINARY);
  endproperty
  a_start: assert property (p_start)
    else $error("bad mode");
  property p_line;
    pump_modulation_on && !transfer_go && $rose(pump_stat.mod_up) |=>
      evt_valid && evt_msg.code == {1'b0, !pump_tx_dir, pump_tx_dir,
      serial_frame_mode == fxp_pkg::FXP_FRM_BINARY};
  endproperty
  a_line: assert property (p_line) else $error("bad line event");
  property p_conn;
    transfer_go && $rose(pump_stat.data_ready) |=>
      ec == fxp_pkg::FXP_EVT_CONNECT;
  endproperty
  a_conn: assert property (p_conn) else $error("no connect");
  property p_off;
    ec == fxp_pkg::FXP_EVT_MOD_OFF |->
      serial_frame_mode == fxp_pkg::FXP_FRM_OFF && !transfer_go;
  endproperty
  a_off: assert property (p_off) else $error("mode kept");
  property p_brk;
    cc == fxp_pkg::FXP_CMD_ABORT && pump_modulation_on && pump_tx_dir
      |-> ##[1:2] pump_break;
  endproperty
  a_brk: assert property (p_brk) else $error("no break");
  property p_abort_idle;
    cc == fxp_pkg::FXP_CMD_ABORT && idle |=> (!evt_valid && !pump_break)[*4];
  endproperty
  a_abort_idle: assert property (p_abort_idle)
    else $error("abort used");
  property p_halt_idle;
    cc == fxp_pkg::FXP_CMD_SHUTDOWN && idle |-> ##[1:2] !pump_enable;
  endproperty
  a_halt_idle: assert property (p_halt_idle)
    else $error("no shutdown");
  property p_halt_busy;
    cc == fxp_pkg::FXP_CMD_SHUTDOWN && serial_frame_mode !=
      fxp_pkg::FXP_FRM_OFF |=> pump_enable && $stable(serial_frame_mode);
  endproperty
  a_halt_busy: assert property (p_halt_busy) else $error("shut down");
  property p_one;
    start && pump_modulation_on |=> $stable(pump_rate)
      && $stable(serial_frame_mode);
  endproperty
  a_one: assert property (p_one) else $error("second start");
  c_conn: cover property (ec == fxp_pkg::FXP_EVT_CONNECT);
  c_brk: cover property (pump_break);
  c_sil: cover property (ec == fxp_pkg::FXP_EVT_SIL_ELAPSE);
endmodule // fxp_props
`default_nettype wire

// ===== design/fxp_ctrl.sv
// fxp_ctrl: fax pump command interpreter and event generator
// assumes host commands are decoded mailbox messages on clk_sys;
// pump status and line silence come from the modem datapath or pins
`timescale 1ns/1ns
`default_nettype none
module fxp_ctrl (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   cmd_valid,
  input  wire fxp_pkg::fxp_cmd_msg_t  cmd_msg,
  input  wire fxp_pkg::fxp_pump_stat_t pump_stat,
  input  wire logic                   line_silent_pin,
  output fxp_pkg::fxp_evt_msg_t       evt_msg,
  output logic                        evt_valid,
  output fxp_pkg::fxp_frame_t         serial_frame_mode,
  output logic                        pump_modulation_on,
  output logic                        pump_tx_dir,
  output logic [15:0]                 pump_rate,
  output logic                        pump_enable,
  output logic                        pump_break,
  output logic                        transfer_go
);

  typedef enum logic [6:0] {
    ST_OFF   = 7'b0000001,
    ST_IDLE  = 7'b0000010,
    ST_START = 7'b0000100,
    ST_WAITC = 7'b0001000,
    ST_XFER  = 7'b0010000,
    ST_STOP  = 7'b0100000,
    ST_SIL   = 7'b1000000
  } fxp_state_t;

  fxp_state_t state_reg;
  fxp_state_t state_next;

  logic        is_tx_reg;
  logic        is_hdlc_reg;
  logic        connected_reg;
  logic        cont_seen_reg;
  logic        flags_d_reg;
  logic [15:0] sil_dur_reg;
  logic        silent_sync;
  logic        sil_elapsed;
  logic        sil_elapsed_d_reg;
  logic        abort_cmd;
  logic        start_cmd;

  fxp_sync3 #(
    .W (1)
  ) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d_in    (line_silent_pin),
    .q_out   (silent_sync)
  );

  fxp_sil_timer u_sil (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .run        (state_reg == ST_SIL),
    .silence_in (silent_sync),
    .duration   (sil_dur_reg),
    .elapsed    (sil_elapsed)
  );

  assign abort_cmd = cmd_valid && cmd_msg.code == fxp_pkg::FXP_CMD_ABORT;
  assign start_cmd = cmd_valid &&
                     (cmd_msg.code == fxp_pkg::FXP_CMD_HDLC_TX ||
                      cmd_msg.code == fxp_pkg::FXP_CMD_HDLC_RX ||
                      cmd_msg.code == fxp_pkg::FXP_CMD_BIN_TX  ||
                      cmd_msg.code == fxp_pkg::FXP_CMD_BIN_RX);

  // procedure sequencing; new procedures only accepted in idle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (cmd_valid && (cmd_msg.code == fxp_pkg::FXP_CMD_ANSWER ||
            cmd_msg.code == fxp_pkg::FXP_ORIGINATE_MODE_CMD)) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (start_cmd) begin
          state_next = ST_START;
        end else if (cmd_valid &&
                     cmd_msg.code == fxp_pkg::FXP_CMD_SIL_WAIT) begin
          state_next = ST_SIL;
        end else if (cmd_valid &&
                     cmd_msg.code == fxp_pkg::FXP_CMD_SHUTDOWN) begin
          state_next = ST_OFF;
        end
      end
      ST_START, ST_WAITC, ST_XFER: begin
        if (abort_cmd) begin
          state_next = ST_STOP;
        end else if (!connected_reg && pump_stat.wrong_carrier) begin
          state_next = ST_IDLE;
        end else if (is_tx_reg && connected_reg && pump_stat.tx_drained) begin
          state_next = ST_STOP;
        end else if (state_reg == ST_START && pump_stat.mod_up) begin
          state_next = ST_WAITC;
        end else if (state_reg == ST_WAITC && cont_seen_reg) begin
          state_next = ST_XFER;
        end
      end
      ST_STOP: begin
        if (pump_stat.mod_stopped) begin
          state_next = ST_IDLE;
        end
      end
      ST_SIL: begin
        if (cmd_valid && cmd_msg.code == fxp_pkg::FXP_CMD_SIL_STOP) begin
          state_next = ST_IDLE;
        end else if (sil_elapsed && !sil_elapsed_d_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // procedure kind, rate and framing latched at start
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      is_tx_reg         <= 1'b0;
      is_hdlc_reg       <= 1'b0;
      pump_rate         <= fxp_pkg::FXP_RATE_RESET;
      serial_frame_mode <= fxp_pkg::FXP_FRM_OFF;
      pump_modulation_on <= 1'b0;
      pump_tx_dir       <= 1'b0;
    end else if (state_reg == ST_IDLE && start_cmd) begin
      is_tx_reg   <= cmd_msg.code == fxp_pkg::FXP_CMD_HDLC_TX ||
                     cmd_msg.code == fxp_pkg::FXP_CMD_BIN_TX;
      is_hdlc_reg <= cmd_msg.code == fxp_pkg::FXP_CMD_HDLC_TX ||
                     cmd_msg.code == fxp_pkg::FXP_CMD_HDLC_RX;
      pump_tx_dir <= cmd_msg.code == fxp_pkg::FXP_CMD_HDLC_TX ||
                     cmd_msg.code == fxp_pkg::FXP_CMD_BIN_TX;
      pump_rate   <= cmd_msg.param;
      pump_modulation_on <= 1'b1;
      case (cmd_msg.code)
        fxp_pkg::FXP_CMD_HDLC_TX,
        fxp_pkg::FXP_CMD_HDLC_RX:
          serial_frame_mode <= fxp_pkg::FXP_FRM_HDLC;
        default:
          serial_frame_mode <= fxp_pkg::FXP_FRM_BINARY;
      endcase
    end else if (state_next == ST_IDLE || state_next == ST_OFF) begin
      pump_modulation_on <= 1'b0;
      serial_frame_mode  <= fxp_pkg::FXP_FRM_OFF;
    end
  end

  // stored silence duration survives between waits
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sil_dur_reg <= fxp_pkg::FXP_SIL_DUR_RESET;
    end else if (state_reg == ST_IDLE && cmd_valid &&
                 cmd_msg.code == fxp_pkg::FXP_CMD_SIL_WAIT &&
                 cmd_msg.has_param) begin
      sil_dur_reg <= cmd_msg.param;
    end
  end

  // connect, continue and edge history
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      connected_reg     <= 1'b0;
      cont_seen_reg     <= 1'b0;
      flags_d_reg       <= 1'b0;
      sil_elapsed_d_reg <= 1'b0;
      transfer_go       <= 1'b0;
      pump_enable       <= 1'b0;
      pump_break        <= 1'b0;
    end else begin
      flags_d_reg       <= pump_stat.flags_seen;
      sil_elapsed_d_reg <= sil_elapsed;
      pump_enable       <= state_next != ST_OFF;
      transfer_go       <= state_next == ST_XFER;
      // break only in transmit; receive abort is a plain escape
      pump_break        <= abort_cmd && is_tx_reg &&
                           state_next == ST_STOP;
      if (state_reg == ST_IDLE) begin
        connected_reg <= 1'b0;
        cont_seen_reg <= 1'b0;
      end else begin
        if (pump_stat.data_ready && !connected_reg &&
            (state_reg == ST_WAITC || state_reg == ST_XFER)) begin
          connected_reg <= 1'b1;
        end
        if (cmd_valid && cmd_msg.code == fxp_pkg::FXP_CMD_CONTINUE) begin
          cont_seen_reg <= 1'b1;
        end
      end
    end
  end

  // event emission; at most one per cycle, priority by order below
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      evt_valid    <= 1'b0;
      evt_msg.code <= fxp_pkg::FXP_EVT_NONE;
      evt_msg.info <= 16'h0000;
    end else begin
      evt_valid    <= 1'b1;
      evt_msg.info <= pump_rate;
      if (state_reg == ST_OFF && state_next == ST_IDLE) begin
        evt_msg.code <= fxp_pkg::FXP_EVT_INIT;
      end else if (state_reg == ST_STOP && state_next == ST_IDLE) begin
        evt_msg.code <= fxp_pkg::FXP_EVT_MOD_OFF;
      end else if (state_reg != ST_IDLE && state_reg != ST_SIL &&
                   state_reg != ST_STOP && state_next == ST_IDLE) begin
        evt_msg.code <= fxp_pkg::FXP_EVT_WRONG_CAR;
      end else if (state_reg == ST_SIL && state_next == ST_IDLE &&
                   sil_elapsed) begin
        evt_msg.code <= fxp_pkg::FXP_EVT_SIL_ELAPSE;
      end else if (state_reg == ST_START && state_next == ST_WAITC) begin
        case ({is_tx_reg, is_hdlc_reg})
          2'b11:   evt_msg.code <= fxp_pkg::FXP_EVT_LINE_HTX;
          2'b10:   evt_msg.code <= fxp_pkg::FXP_EVT_LINE_BTX;
          2'b01:   evt_msg.code <= fxp_pkg::FXP_EVT_LINE_HRX;
          default: evt_msg.code <= fxp_pkg::FXP_EVT_LINE_BRX;
        endcase
      end else if (pump_stat.data_ready && !connected_reg &&
                   (state_reg == ST_WAITC || state_reg == ST_XFER)) begin
        evt_msg.code <= fxp_pkg::FXP_EVT_CONNECT;
      end else if (pump_stat.flags_seen && !flags_d_reg && is_hdlc_reg &&
                   !is_tx_reg && state_reg != ST_IDLE &&
                   state_reg != ST_OFF) begin
        evt_msg.code <= fxp_pkg::FXP_EVT_FLAGS;
      end else begin
        evt_valid    <= 1'b0;
        evt_msg.code <= fxp_pkg::FXP_EVT_NONE;
      end
    end
  end
  // payload moves in separate frame data messages, outside this block

endmodule // fxp_ctrl
`default_nettype wire

// ===== design/fxp_pkg.sv
// fxp_pkg: shared types and constants for the fax pump control block
// assumes one 250 MHz clock; host commands arrive already decoded
// Operation
// - hdlc tx: hdlc framing, modulation, tx rate
// - hdlc rx: hdlc framing, modulation, rx rate
// - binary tx: binary framing, modulation, tx rate
// - binary rx: binary framing, modulation, rx rate
// - silence wait uses parameter or stored duration
// - abort: escape in receive, break in transmit
// - silence stop ends ongoing silence detection
// - shutdown while idle shuts pump down
// - answer/originate answered with pump initialised
// - modulation established event per start command
// - connect event when pump ready for data
// - disconnect event after modulation turned off
// - wrong carrier event before connect only
// - silence elapsed event after stored duration
// - flags event on recognised hdlc flags
// - payload in frame data messages with control
// - only one procedure active at once
// - abort ignored while pump idle
package fxp_pkg;

  typedef enum logic [3:0] {
    FXP_CMD_NONE      = 4'h0,
    FXP_CMD_ANSWER    = 4'h1,
    FXP_ORIGINATE_MODE_CMD = 4'h2,
    FXP_CMD_HDLC_TX   = 4'h3,
    FXP_CMD_HDLC_RX   = 4'h4,
    FXP_CMD_BIN_TX    = 4'h5,
    FXP_CMD_BIN_RX    = 4'h6,
    FXP_CMD_SIL_WAIT  = 4'h7,
    FXP_CMD_SIL_STOP  = 4'h8,
    FXP_CMD_CONTINUE  = 4'h9,
    FXP_CMD_ABORT     = 4'hA,
    FXP_CMD_SHUTDOWN  = 4'hB
  } fxp_cmd_t;

  typedef enum logic [3:0] {
    FXP_EVT_NONE       = 4'h0,
    FXP_EVT_INIT       = 4'h1,
    FXP_EVT_LINE_HTX   = 4'h2,
    FXP_EVT_LINE_BTX   = 4'h3,
    FXP_EVT_LINE_HRX   = 4'h4,
    FXP_EVT_LINE_BRX   = 4'h5,
    FXP_EVT_CONNECT    = 4'h6,
    FXP_EVT_MOD_OFF    = 4'h7,
    FXP_EVT_WRONG_CAR  = 4'h8,
    FXP_EVT_SIL_ELAPSE = 4'h9,
    FXP_EVT_FLAGS      = 4'hA
  } fxp_evt_t;

  typedef enum logic [1:0] {
    FXP_FRM_OFF    = 2'h0,
    FXP_FRM_HDLC   = 2'h1,
    FXP_FRM_BINARY = 2'h2
  } fxp_frame_t;

  // command from host mailbox, one-cycle valid
  typedef struct packed {
    fxp_cmd_t    code;
    logic        has_param;
    logic [15:0] param;
  } fxp_cmd_msg_t;

  // event toward host mailbox
  typedef struct packed {
    fxp_evt_t    code;
    logic [15:0] info;
  } fxp_evt_msg_t;

  // status reported by the modem datapath
  typedef struct packed {
    logic mod_up;
    logic data_ready;
    logic tx_drained;
    logic mod_stopped;
    logic wrong_carrier;
    logic flags_seen;
  } fxp_pump_stat_t;

  // silence duration unit and its cycle count
  localparam int          FXP_CLK_MHZ       = 250;
  localparam int          FXP_SIL_UNIT_US   = 10;
  localparam int          FXP_SIL_UNIT_CYC  = FXP_SIL_UNIT_US * FXP_CLK_MHZ;
  localparam logic [15:0] FXP_SIL_DUR_RESET = 16'h0064;
  localparam logic [15:0] FXP_RATE_RESET    = 16'h0000;

endpackage : fxp_pkg

// ===== design/fxp_sil_timer.sv
// fxp_sil_timer: counts silence duration in units of a divided tick
// assumes silence_in is already synchronous
`timescale 1ns/1ns
`default_nettype none
module fxp_sil_timer #(
  parameter int UNIT_CYC = fxp_pkg::FXP_SIL_UNIT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic        silence_in,
  input  wire logic [15:0] duration,
  output logic             elapsed
);
  logic [$clog2(UNIT_CYC+1)-1:0] div_reg;
  logic                          tick;
  logic [15:0]                   units_reg;

  // one-cycle tick per unit; restarts on any line energy
  always_ff @(posedge clk_sys) begin
    if (!resetn || !run || !silence_in) begin
      div_reg <= '0;
      tick    <= 1'b0;
    end else if (div_reg == ($clog2(UNIT_CYC+1))'(UNIT_CYC - 1)) begin
      div_reg <= '0;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 1'b1;
      tick    <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || !run || !silence_in) begin
      units_reg <= '0;
      elapsed   <= 1'b0;
    end else if (tick && !elapsed) begin
      units_reg <= units_reg + 16'h0001;
      elapsed   <= (units_reg + 16'h0001) >= duration;
    end
  end
endmodule // fxp_sil_timer
`default_nettype wire

// ===== design/fxp_sync3.sv
// fxp_sync3: three-stage input synchroniser, change taken when 2 and 3 agree
// assumes input is asynchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
module fxp_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // s1 feeds only s2, avoiding metastable fanout
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_out  <= '0;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // fxp_sync3
`default_nettype wire
